/* rtl/mux_bus_pkg.sv */
`default_nettype none
package mux_bus_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADW = 8;                 // Shared address/data width

  typedef logic [ADW-1:0] byte_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam byte_t BYTE_RST = 8'h00;
  localparam logic  PIN_IDLE = 1'b1;             // Idle level of select and strobes

  // ----------------------------------------------------------------
  // Host strobe timing, in ns, rounded up to mclk cycles
  // ----------------------------------------------------------------
  localparam int unsigned PHASE_NS     = 24;       // Least width of each strobe phase
  localparam int unsigned CLK_NS       = 8;        // mclk period
  localparam int unsigned PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  PHASE_CYC_W  = 4'(PHASE_CYC);

  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    H_IDLE  = 7'b000_0001,
    H_SEL   = 7'b000_0010,
    H_ADDR  = 7'b000_0100,
    H_LATCH = 7'b000_1000,
    H_STRB  = 7'b001_0000,
    H_REL   = 7'b010_0000,
    H_DONE  = 7'b100_0000
  } host_state_e;

endpackage : mux_bus_pkg
`default_nettype wire

/* rtl/mux_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mux_bus_if;
  import mux_bus_pkg::*;

  logic  chipSelectN;
  logic  address_latch_strobe_n;
  logic  read_strobe_n;
  logic  write_strobe_n;
  byte_t adHostOut;
  logic  adHostOe;
  byte_t adDevOut;
  logic  adDevOe;
  byte_t adIn;

  // Wire level of the shared lines, worked out from both enables
  always_comb begin
    if (adDevOe) begin
      adIn = adDevOut;
    end else if (adHostOe) begin
      adIn = adHostOut;
    end else begin
      adIn = 8'hFF;                                  // Pull-up when idle
    end
  end

  modport device (
    input  chipSelectN, address_latch_strobe_n, read_strobe_n, write_strobe_n, adIn,
    output adDevOut, adDevOe
  );
  modport host (
    input  adIn,
    output chipSelectN, address_latch_strobe_n, read_strobe_n, write_strobe_n,
    output adHostOut, adHostOe
  );
endinterface : mux_bus_if
`default_nettype wire

/* rtl/mux_bus_device.sv */
// Function
// - Capture address on latch strobe rising edge
// - Latch strobe high means data phase
// - Read strobe fall starts register read
// - Device drives byte; host samples on rise
// - Write strobe fall starts register write
// - Write byte stored on write strobe rise
// - Chip select fall starts; strobe picks direction
`timescale 1ns/1ps
`default_nettype none
module mux_bus_device (
  input  wire logic                mclk,
  input  wire logic                rst,
  mux_bus_if.device                bus,
  input  wire mux_bus_pkg::byte_t  regRdData,
  output logic                     regRdStart,
  output logic                     regWrStart,
  output logic                     regWrStore,
  output mux_bus_pkg::byte_t       regAddr,
  output mux_bus_pkg::byte_t       regWrData,
  output logic                     accessStart
);
  import mux_bus_pkg::*;

  // ----------------------------------------------------------------
  // Edge helpers
  // ----------------------------------------------------------------
  // Falling edge, from last cycle's level and this cycle's
  // Kept as functions so every pin is edged the same way
  function automatic logic fellEdge(
    input logic prevLevel,
    input logic nowLevel
  );
    return prevLevel && !nowLevel;
  endfunction : fellEdge

  // Rising edge, for the latch strobe and the write strobe
  function automatic logic roseEdge(
    input logic prevLevel,
    input logic nowLevel
  );
    return !prevLevel && nowLevel;
  endfunction : roseEdge

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  // Whole state in one record, registered in one place
  typedef struct packed {
    // Pin levels one cycle back, for edge finding
    logic  csPrev;
    logic  llaPrev;
    logic  rdPrev;
    logic  wrPrev;
    // Open from a select fall until deselect
    logic  inAccess;
    // Latched address and the byte of each direction
    byte_t addr;
    byte_t wrData;
    byte_t rdData;
    // Enable of the shared lines
    logic  drive;
    // One-cycle pulses to the register side
    logic  rdStart;
    logic  wrStart;
    logic  wrStore;
    logic  accStart;
  } dev_s;

  dev_s st_r;
  dev_s st_nxt;

  // ----------------------------------------------------------------
  // Pin events
  // ----------------------------------------------------------------
  logic csFall;
  logic llaRise;
  logic rdFall;
  logic wrFall;
  logic wrRise;
  logic selected;
  logic dataPhase;

  // Edges land one cycle late; pins are taken as synchronous
  // A level held for less than one mclk is never seen
  assign csFall    = fellEdge(st_r.csPrev, bus.chipSelectN);
  assign llaRise   = roseEdge(st_r.llaPrev, bus.address_latch_strobe_n);
  assign rdFall    = fellEdge(st_r.rdPrev, bus.read_strobe_n);
  assign wrFall    = fellEdge(st_r.wrPrev, bus.write_strobe_n);
  assign wrRise    = roseEdge(st_r.wrPrev, bus.write_strobe_n);

  // Strobes only count in the data phase of an opened access
  // Stray strobes outside an access are simply ignored
  assign selected  = !bus.chipSelectN;
  assign dataPhase = selected && st_r.inAccess && bus.address_latch_strobe_n;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Pulses default low, so each stands for exactly one cycle
  always_comb begin
    st_nxt          = st_r;
    st_nxt.csPrev   = bus.chipSelectN;
    st_nxt.llaPrev  = bus.address_latch_strobe_n;
    st_nxt.rdPrev   = bus.read_strobe_n;
    st_nxt.wrPrev   = bus.write_strobe_n;
    st_nxt.rdStart  = 1'b0;
    st_nxt.wrStart  = 1'b0;
    st_nxt.wrStore  = 1'b0;
    st_nxt.accStart = 1'b0;

    // --------------------------------------------------------------
    // Access tracking
    // --------------------------------------------------------------
    // Only a select fall opens an access; deselect closes it
    // Reset history is idle, so a select low at release counts as a fall
    if (csFall) begin
      st_nxt.inAccess = 1'b1;
      st_nxt.accStart = 1'b1;
    end else if (!selected) begin
      st_nxt.inAccess = 1'b0;
    end

    // --------------------------------------------------------------
    // Address latch
    // --------------------------------------------------------------
    // Taken on the latch rise, while the host still drives the address
    // Lines are host driven then; a later sample could see data
    if (llaRise && selected && st_r.inAccess) begin
      st_nxt.addr = bus.adIn;
    end

    // --------------------------------------------------------------
    // Read path
    // --------------------------------------------------------------
    // Byte frozen at the strobe fall; a register that changes later
    // in the strobe is not seen until the next read
    if (dataPhase && rdFall) begin
      st_nxt.rdStart = 1'b1;
      st_nxt.rdData  = regRdData;
    end

    // --------------------------------------------------------------
    // Write path
    // --------------------------------------------------------------
    // Write starts on the fall; the byte is taken on the rise
    // Host keeps the byte on the lines through the rise
    if (dataPhase && wrFall) begin
      st_nxt.wrStart = 1'b1;
    end
    if (dataPhase && wrRise) begin
      st_nxt.wrData  = bus.adIn;
      st_nxt.wrStore = 1'b1;
    end

    // --------------------------------------------------------------
    // Line drive
    // --------------------------------------------------------------
    // Drive only while selected and reading; never fights the host
    // Enable follows the strobe by one cycle both ways
    st_nxt.drive = selected && !bus.read_strobe_n
                   && bus.address_latch_strobe_n;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Edge history resets to the idle pin level: no false edge after reset
  // Pulses and bytes start at zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r.csPrev   <= PIN_IDLE;
      st_r.llaPrev  <= PIN_IDLE;
      st_r.rdPrev   <= PIN_IDLE;
      st_r.wrPrev   <= PIN_IDLE;
      st_r.inAccess <= 1'b0;
      st_r.addr     <= BYTE_RST;
      st_r.wrData   <= BYTE_RST;
      st_r.rdData   <= BYTE_RST;
      st_r.drive    <= 1'b0;
      st_r.rdStart  <= 1'b0;
      st_r.wrStart  <= 1'b0;
      st_r.wrStore  <= 1'b0;
      st_r.accStart <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Shared lines
  // ----------------------------------------------------------------
  // Straight from the record; turnaround costs one cycle
  assign bus.adDevOut = st_r.rdData;
  assign bus.adDevOe  = st_r.drive;

  // ----------------------------------------------------------------
  // Register side
  // ----------------------------------------------------------------
  // Pulses last one cycle; levels hold until replaced
  assign regRdStart   = st_r.rdStart;
  assign regWrStart   = st_r.wrStart;
  assign regWrStore   = st_r.wrStore;
  assign regAddr      = st_r.addr;
  assign regWrData    = st_r.wrData;
  assign accessStart  = st_r.accStart;
endmodule : mux_bus_device
`default_nettype wire

/* rtl/mux_bus_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mux_bus_host (
  input  wire logic                mclk,
  input  wire logic                rst,
  mux_bus_if.host                  bus,
  input  wire logic                reqValid,
  input  wire logic                reqWrite,
  input  wire mux_bus_pkg::byte_t  reqAddr,
  input  wire mux_bus_pkg::byte_t  reqData,
  output logic                     reqBusy,
  output logic                     rspValid,
  output mux_bus_pkg::byte_t       rspData
);
  import mux_bus_pkg::*;

  typedef struct packed {
    host_state_e state;
    logic [3:0]  cnt;
    logic        write;
    byte_t       addr;
    byte_t       data;
    logic        csN;
    logic        llaN;
    logic        rdN;
    logic        wrN;
    logic        oe;
    byte_t       adOut;
    logic        busy;
    logic        rspV;
    byte_t       rsp;
  } host_s;

  host_s st_r;
  host_s st_nxt;

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // Each strobe phase held PHASE_CYC + 1 cycles so the device sees clean edges
  always_comb begin
    st_nxt      = st_r;
    st_nxt.rspV = 1'b0;
    if (st_r.cnt != 4'h0) begin
      st_nxt.cnt = st_r.cnt - 4'h1;
    end else begin
      case (st_r.state)
        H_IDLE: begin
          if (reqValid) begin
            st_nxt.write = reqWrite;
            st_nxt.addr  = reqAddr;
            st_nxt.data  = reqData;
            st_nxt.busy  = 1'b1;
            st_nxt.csN   = 1'b0;
            st_nxt.state = H_SEL;
            st_nxt.cnt   = PHASE_CYC_W;
          end
        end
        H_SEL: begin
          st_nxt.llaN  = 1'b0;
          st_nxt.oe    = 1'b1;
          st_nxt.adOut = st_r.addr;
          st_nxt.state = H_ADDR;
          st_nxt.cnt   = PHASE_CYC_W;
        end
        H_ADDR: begin
          st_nxt.llaN  = 1'b1;
          st_nxt.state = H_LATCH;
          st_nxt.cnt   = PHASE_CYC_W;
        end
        H_LATCH: begin
          // Data phase: write data out, or lines released for read
          st_nxt.oe    = st_r.write;
          st_nxt.adOut = st_r.data;
          st_nxt.rdN   = st_r.write;
          st_nxt.wrN   = !st_r.write;
          st_nxt.state = H_STRB;
          st_nxt.cnt   = PHASE_CYC_W;
        end
        H_STRB: begin
          if (!st_r.write) begin
            st_nxt.rsp  = bus.adIn;
            st_nxt.rspV = 1'b1;
          end
          st_nxt.rdN   = 1'b1;
          st_nxt.wrN   = 1'b1;
          st_nxt.state = H_REL;
          st_nxt.cnt   = PHASE_CYC_W;
        end
        H_REL: begin
          st_nxt.oe    = 1'b0;
          st_nxt.csN   = 1'b1;
          st_nxt.state = H_DONE;
        end
        H_DONE: begin
          st_nxt.busy  = 1'b0;
          st_nxt.state = H_IDLE;
        end
        default: begin
          st_nxt.state = H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r       <= '0;
      st_r.state <= H_IDLE;
      st_r.csN   <= 1'b1;
      st_r.llaN  <= 1'b1;
      st_r.rdN   <= 1'b1;
      st_r.wrN   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.chipSelectN            = st_r.csN;
  assign bus.address_latch_strobe_n = st_r.llaN;
  assign bus.read_strobe_n          = st_r.rdN;
  assign bus.write_strobe_n         = st_r.wrN;
  assign bus.adHostOut              = st_r.adOut;
  assign bus.adHostOe               = st_r.oe;
  assign reqBusy                    = st_r.busy;
  assign rspValid                   = st_r.rspV;
  assign rspData                    = st_r.rsp;
endmodule : mux_bus_host
`default_nettype wire

/* sim/mux_bus_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mux_bus_assertions (
  input wire logic                mclk,
  input wire logic                rst,
  input wire logic                chipSelectN,
  input wire logic                address_latch_strobe_n,
  input wire logic                read_strobe_n,
  input wire logic                write_strobe_n,
  input wire mux_bus_pkg::byte_t  adHostOut,
  input wire logic                adHostOe,
  input wire mux_bus_pkg::byte_t  adDevOut,
  input wire logic                adDevOe,
  input wire mux_bus_pkg::byte_t  adIn
);
  import mux_bus_pkg::*;
  // --------------------------------------------------------------
  // Wire protocol checks, one clock domain
  // --------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_addr_lat;
    $rose(address_latch_strobe_n) |-> !chipSelectN && adHostOe && !adDevOe && adIn == adHostOut;
  endproperty
  a_addr_lat: assert property (p_addr_lat) else $error("address not driven at latch");
  property p_addr_phase;
    !address_latch_strobe_n |-> !adDevOe && read_strobe_n && write_strobe_n;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("data during address phase");
  property p_rd_drive;
    !chipSelectN && !read_strobe_n && address_latch_strobe_n |=> adDevOe;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read byte not driven");
  property p_rd_hold;
    $rose(read_strobe_n) |-> adDevOe && adIn == adDevOut;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte gone at strobe rise");
  property p_wr_drive;
    !write_strobe_n |-> adHostOe && !adDevOe;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not host driven");
  property p_wr_hold;
    (!write_strobe_n ##1 !write_strobe_n) |-> $stable(adHostOut);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
  property p_strb_cs;
    (!read_strobe_n || !write_strobe_n) |-> !chipSelectN && (read_strobe_n || write_strobe_n);
  endproperty
  a_strb_cs: assert property (p_strb_cs) else $error("strobe outside select");
  property p_cs_first;
    $fell(chipSelectN) |-> address_latch_strobe_n && read_strobe_n && write_strobe_n
      ##[1:6] !address_latch_strobe_n;
  endproperty
  a_cs_first: assert property (p_cs_first) else $error("access not opened by select");
  property p_release;
    (chipSelectN || read_strobe_n) |=> !adDevOe;
  endproperty
  a_release: assert property (p_release) else $error("device holds lines");
  property p_no_fight;
    !(adDevOe && adHostOe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive");
endmodule : mux_bus_assertions
`default_nettype wire

/* sim/multiplexed_host_bus_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module multiplexed_host_bus_port_tb;
  import mux_bus_pkg::*;
  // --------------------------------------------------------------
  // Stimulus, observation and wiring
  // --------------------------------------------------------------
  logic  mclk      = 1'b0;
  logic  rst       = 1'b1;
  logic  reqValid  = 1'b0;
  logic  reqWrite  = 1'b0;
  byte_t reqAddr   = BYTE_RST;
  byte_t reqData   = BYTE_RST;
  byte_t regRdData = BYTE_RST;
  logic  prevLla   = 1'b1;
  logic  prevRd    = 1'b1;
  logic  reqBusy, rspValid, regRdStart, regWrStart, regWrStore, accessStart;
  byte_t rspData, regAddr, regWrData, rdSeen, wrAddrSeen, wrDataSeen, wireAddr, wireRd;
  byte_t mem [256];
  byte_t tA [4] = '{8'h00, 8'hFF, 8'hA5, 8'h3C};
  byte_t tD [4] = '{8'hFF, 8'h00, 8'h5A, 8'hC3};
  int    nRd, nWr, nAcc, cycles, error_cnt, check_count;

  always #4 mclk = ~mclk;

  mux_bus_if mux_bus_if_inst ();
  mux_bus_host mux_bus_host_inst (.mclk(mclk), .rst(rst), .bus(mux_bus_if_inst),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .reqBusy(reqBusy), .rspValid(rspValid), .rspData(rspData));
  mux_bus_device mux_bus_device_inst (.mclk(mclk), .rst(rst), .bus(mux_bus_if_inst),
    .regRdData(regRdData), .regRdStart(regRdStart), .regWrStart(regWrStart),
    .regWrStore(regWrStore), .regAddr(regAddr), .regWrData(regWrData),
    .accessStart(accessStart));
  mux_bus_assertions mux_bus_assertions_inst (.mclk(mclk), .rst(rst),
    .chipSelectN(mux_bus_if_inst.chipSelectN),
    .address_latch_strobe_n(mux_bus_if_inst.address_latch_strobe_n),
    .read_strobe_n(mux_bus_if_inst.read_strobe_n),
    .write_strobe_n(mux_bus_if_inst.write_strobe_n),
    .adHostOut(mux_bus_if_inst.adHostOut), .adHostOe(mux_bus_if_inst.adHostOe),
    .adDevOut(mux_bus_if_inst.adDevOut), .adDevOe(mux_bus_if_inst.adDevOe),
    .adIn(mux_bus_if_inst.adIn));

  // Register file behind the device, plus wire snapshots at strobe rises
  always @(posedge mclk) begin
    regRdData <= mem[regAddr];
    prevLla   <= mux_bus_if_inst.address_latch_strobe_n;
    prevRd    <= mux_bus_if_inst.read_strobe_n;
    cycles    <= cycles + 1;
    if (mux_bus_if_inst.address_latch_strobe_n && !prevLla) wireAddr <= mux_bus_if_inst.adIn;
    if (mux_bus_if_inst.read_strobe_n && !prevRd) wireRd <= mux_bus_if_inst.adIn;
    if (regWrStore) begin
      mem[regAddr] <= regWrData;
      wrAddrSeen   <= regAddr;
      wrDataSeen   <= regWrData;
    end
    if (rspValid) rdSeen <= rspData;
    if (regRdStart) nRd <= nRd + 1;
    if (regWrStart) nWr <= nWr + 1;
    if (accessStart) nAcc <= nAcc + 1;
    // About 20 cycles per access; a hang runs far past this
    if (cycles == 2000) begin
      error_cnt++;
      results();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input byte_t got, input byte_t exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Request held two edges: the second lands while busy and must be refused
  task automatic access(input logic wr, input byte_t a, input byte_t d);
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddr  <= a;
    reqData  <= d;
    repeat (2) @(posedge mclk);
    reqValid <= 1'b0;
    for (int i = 0; i < 60 && reqBusy !== 1'b0; i++) @(posedge mclk);
    @(posedge mclk);
  endtask : access

  // Host-side write and read, one access each
  task automatic write_byte(input byte_t a, input byte_t d);
    access(1'b1, a, d);
  endtask : write_byte

  task automatic read_byte(input byte_t a);
    access(1'b0, a, BYTE_RST);
  endtask : read_byte

  task automatic results();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // --------------------------------------------------------------
  // Sequence: preset read, writes at edge and pattern addresses, read back
  // --------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    read_byte(8'h3C);
    chk(rdSeen, 8'h3C ^ 8'h5A);
    chk(wireAddr, 8'h3C);
    foreach (tA[k]) begin
      write_byte(tA[k], tD[k]);
      chk(wrAddrSeen, tA[k]);
      chk(wrDataSeen, tD[k]);
      chk(wireAddr, tA[k]);
    end
    foreach (tA[k]) begin
      read_byte(tA[k]);
      chk(rdSeen, tD[k]);
      chk(wireRd, tD[k]);
      chk(mux_bus_if_inst.adIn, 8'hFF);
    end
    chk(8'(nRd), 8'h05);
    chk(8'(nWr), 8'h04);
    chk(8'(nAcc), 8'h09);
    results();
  end
endmodule : multiplexed_host_bus_port_tb
`default_nettype wire
